// >>> rtopt_defs.vh
`ifndef RTOPT_DEFS_VH
`define RTOPT_DEFS_VH

// register word indices (printed offsets are not multiples of four)
`define RTOPT_IDX_OPTIONS      8'h4D
`define RTOPT_IDX_PENDING      8'h09
`define RTOPT_IDX_IRQ_STATUS   8'h80
`define RTOPT_IDX_IRQ_MASK     8'h81
`define RTOPT_IDX_LOG_WORD     8'h82
`define RTOPT_IDX_MSG_INFO     8'h83

// option register fields
`define RTOPT_OPT_RESET        16'h0000
`define RTOPT_OPT_WMASK        16'h001F
`define RTOPT_BIT_RSVD4        4
`define RTOPT_BIT_FLAG_SELECT  3
`define RTOPT_BIT_BUSY_REPORT  2
`define RTOPT_BIT_PING_PONG    1

// message information word and identification word fields
`define RTOPT_BIT_GAP_OR_BROADCAST_FLAG    13
`define RTOPT_BIT_BUSY_EVENT   9
`define RTOPT_EVENT_LSB        0
`define RTOPT_EVENT_W          9
`define RTOPT_MSG_LOW_W        13

// interrupt status bits
`define RTOPT_IRQ_LOGGED       0
`define RTOPT_IRQ_MSGINFO      1
`define RTOPT_IRQ_W            2

`define RTOPT_ZERO16           16'h0000
`define RTOPT_ZERO32           32'h00000000

`endif

// >>> rtopt_top.v
// What this block does
// RQ1: option register sits at word offset 0x4D
// RQ2: only low option bits; bits 15-5 unused
// RQ3: software keeps bit 4 at zero
// RQ4: flag-select zero: bit 13 reports gap error
// RQ5: flag-select one: bit 13 reports broadcast
// RQ6: busy-report set: busy event sets log bit 9
// RQ7: not busy: only event flags logged
// RQ8: busy-report clear: log bit 9 always zero
// RQ9: log entry only on enabled interrupt event
// RQ10: busy alone causes no log entry
// RQ11: pending register bit 9 stays reserved
// RQ12: option register resets to all zeros
// RQ13: unused bits read zero, writes ignored
`timescale 1ns/1ps
`include "rtopt_defs.vh"

module rtopt_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // message completion from the terminal core
  input  wire        msg_done,
  input  wire [12:0] msg_info_low,
  input  wire        msg_gap_error,
  input  wire        msg_broadcast,
  // interrupt events from the terminal core, one bit per source
  input  wire [8:0]  event_raw,
  input  wire [8:0]  event_enable,
  input  wire        terminal_busy,
  output reg  [15:0] msg_info_word,
  output reg         msg_info_valid,
  output reg  [15:0] log_word,
  output reg         log_write,
  output reg         ping_pong_toggle_off,
  output reg         irq
);

  reg  [15:0] options_q;
  reg  [15:0] pending_q;
  reg  [15:0] last_log_q;
  reg  [15:0] last_msg_q;
  reg  [1:0]  irq_status_q;
  reg  [1:0]  irq_mask_q;

  wire [9:0]  word_idx = paddr[11:2];
  wire        idx_hit_opt  = (word_idx == {2'b00, `RTOPT_IDX_OPTIONS});
  wire        idx_hit_pend = (word_idx == {2'b00, `RTOPT_IDX_PENDING});
  wire        idx_hit_sts  = (word_idx == {2'b00, `RTOPT_IDX_IRQ_STATUS});
  wire        idx_hit_msk  = (word_idx == {2'b00, `RTOPT_IDX_IRQ_MASK});
  wire        idx_hit_log  = (word_idx == {2'b00, `RTOPT_IDX_LOG_WORD});
  wire        idx_hit_msg  = (word_idx == {2'b00, `RTOPT_IDX_MSG_INFO});
  wire        idx_valid    = idx_hit_opt | idx_hit_pend | idx_hit_sts |
                             idx_hit_msk | idx_hit_log | idx_hit_msg;

  // setup phase raises pready, so every access finishes in its second cycle
  wire        access   = psel & penable & pready;
  wire        wr_fire  = access & pwrite;

  wire        flag_sel  = options_q[`RTOPT_BIT_FLAG_SELECT];
  wire        busy_rep  = options_q[`RTOPT_BIT_BUSY_REPORT];
  wire [8:0]  ev_hits   = event_raw & event_enable;
  wire        ev_any    = |ev_hits;

  // message word: bit 13 meaning chosen by flag-select
  reg  [15:0] msg_d;
  always @* begin
    msg_d = {2'b00, 1'b0, msg_info_low};
    if (flag_sel) begin
      msg_d[`RTOPT_BIT_GAP_OR_BROADCAST_FLAG] = msg_broadcast; // RQ5
    end else begin
      msg_d[`RTOPT_BIT_GAP_OR_BROADCAST_FLAG] = msg_gap_error; // RQ4
    end
  end

  // identification word for the log buffer
  reg  [15:0] log_d;
  always @* begin
    log_d = `RTOPT_ZERO16;
    log_d[`RTOPT_EVENT_W-1:`RTOPT_EVENT_LSB] = ev_hits; // RQ7
    // busy is only a qualifier, never a cause of its own
    log_d[`RTOPT_BIT_BUSY_EVENT] = busy_rep & terminal_busy; // RQ6 RQ8
  end

  // pending register: event bits only, bit 9 never set by busy
  wire [15:0] pend_d = pending_q |
                       {7'h00, ev_hits}; // RQ11

  wire [1:0]  irq_set = {msg_done, ev_any};

  // option register: only the writable bits are kept
  reg  [15:0] options_d;
  always @* begin
    options_d = options_q;
    if (wr_fire && idx_hit_opt) begin
      // bit 4 is stored as written; software must keep it zero
      options_d = pwdata[15:0] & `RTOPT_OPT_WMASK; // RQ1 RQ2 RQ13
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options_q <= `RTOPT_OPT_RESET; // RQ12
    end else begin
      options_q <= options_d;
    end
  end

  // interrupt mask
  reg  [1:0]  irq_mask_d;
  always @* begin
    irq_mask_d = irq_mask_q;
    if (wr_fire && idx_hit_msk) begin
      irq_mask_d = pwdata[`RTOPT_IRQ_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 2'b00;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // pending clears on read; a same-cycle event still lands
  reg  [15:0] pending_d;
  always @* begin
    pending_d = pend_d;
    if (access && !pwrite && idx_hit_pend) begin
      pending_d = {7'h00, ev_hits}; // RQ11
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= `RTOPT_ZERO16;
    end else begin
      pending_q <= pending_d;
    end
  end

  // set wins over write-one-to-clear
  reg  [1:0]  irq_status_d;
  always @* begin
    irq_status_d = irq_status_q | irq_set;
    if (wr_fire && idx_hit_sts) begin
      irq_status_d = (irq_status_q & ~pwdata[`RTOPT_IRQ_W-1:0]) | irq_set;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 2'b00;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // last identification word, kept for software
  reg  [15:0] last_log_d;
  always @* begin
    last_log_d = last_log_q;
    if (ev_any) begin
      last_log_d = log_d; // RQ9 RQ10
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_log_q <= `RTOPT_ZERO16;
    end else begin
      last_log_q <= last_log_d;
    end
  end

  // last message word, kept for software
  reg  [15:0] last_msg_d;
  always @* begin
    last_msg_d = last_msg_q;
    if (msg_done) begin
      last_msg_d = msg_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_msg_q <= `RTOPT_ZERO16;
    end else begin
      last_msg_q <= last_msg_d;
    end
  end

  // outputs, each straight from its own flip-flop
  reg         msg_info_valid_d;
  always @* begin
    msg_info_valid_d = msg_done;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_info_valid <= 1'b0;
    end else begin
      msg_info_valid <= msg_info_valid_d;
    end
  end

  reg  [15:0] msg_info_word_d;
  always @* begin
    msg_info_word_d = msg_info_word;
    if (msg_done) begin
      msg_info_word_d = msg_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_info_word <= `RTOPT_ZERO16;
    end else begin
      msg_info_word <= msg_info_word_d;
    end
  end

  reg         log_write_d;
  always @* begin
    log_write_d = ev_any; // RQ9 RQ10
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_write <= 1'b0;
    end else begin
      log_write <= log_write_d;
    end
  end

  reg  [15:0] log_word_d;
  always @* begin
    log_word_d = log_word;
    if (ev_any) begin
      log_word_d = log_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_word <= `RTOPT_ZERO16;
    end else begin
      log_word <= log_word_d;
    end
  end

  reg         ping_pong_toggle_off_d;
  always @* begin
    ping_pong_toggle_off_d = options_q[`RTOPT_BIT_PING_PONG];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ping_pong_toggle_off <= 1'b0;
    end else begin
      ping_pong_toggle_off <= ping_pong_toggle_off_d;
    end
  end

  // level output lags the status by one cycle
  reg         irq_d;
  always @* begin
    irq_d = |(irq_status_q & irq_mask_q);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // apb slave: one wait-free access phase
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = `RTOPT_ZERO32;
    if (idx_hit_opt) begin
      rdata_d = {16'h0000, options_q}; // RQ13
    end else if (idx_hit_pend) begin
      rdata_d = {16'h0000, pending_q};
    end else if (idx_hit_sts) begin
      rdata_d = {30'h00000000, irq_status_q};
    end else if (idx_hit_msk) begin
      rdata_d = {30'h00000000, irq_mask_q};
    end else if (idx_hit_log) begin
      rdata_d = {16'h0000, last_log_q};
    end else if (idx_hit_msg) begin
      rdata_d = {16'h0000, last_msg_q};
    end
  end

  // answer one cycle after setup: no wait states
  reg         pready_d;
  always @* begin
    pready_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_d;
    end
  end

  // writes return zero; the read word is launched with pready
  reg  [31:0] prdata_d;
  always @* begin
    prdata_d = `RTOPT_ZERO32;
    if (psel && !penable && !pwrite) begin
      prdata_d = rdata_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RTOPT_ZERO32;
    end else begin
      prdata <= prdata_d;
    end
  end

  // unmapped index answers with an error
  reg         pslverr_d;
  always @* begin
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pslverr_d = ~idx_valid;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

endmodule // rtopt_top

// >>> rtopt_properties.sv
`timescale 1ns/1ps
module rtopt_properties (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        msg_done,
  input wire [12:0] msg_info_low,
  input wire [8:0]  event_raw,
  input wire [8:0]  event_enable,
  input wire        terminal_busy,
  input wire [15:0] msg_info_word,
  input wire        msg_info_valid,
  input wire [15:0] log_word,
  input wire        log_write
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_idle: assert property (!psel |-> !pready) else $error("stray ready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_log_cause: assert property (log_write |-> $past(|(event_raw & event_enable)))
    else $error("log without event");
  a_log_bits: assert property (log_write |-> log_word[8:0] == $past(event_raw & event_enable))
    else $error("log event bits");
  a_log_upper: assert property (log_write |-> log_word[15:10] == 6'h00) else $error("log high bits");
  a_busy_cause: assert property (log_write && log_word[9] |-> $past(terminal_busy))
    else $error("busy bit without busy");
  a_msg_pulse: assert property (msg_done |=> msg_info_valid) else $error("no message word");
  a_msg_low: assert property (msg_info_valid |-> msg_info_word[12:0] == $past(msg_info_low)
    && msg_info_word[15:14] == 2'h0) else $error("message word bits");
  c_log: cover property (log_write && log_word[9]);
  c_msg: cover property (msg_info_valid && msg_info_word[13]);
  c_err: cover property (pslverr);
endmodule // rtopt_properties
bind rtopt_top rtopt_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .msg_done(msg_done),
  .msg_info_low(msg_info_low), .event_raw(event_raw), .event_enable(event_enable),
  .terminal_busy(terminal_busy), .msg_info_word(msg_info_word),
  .msg_info_valid(msg_info_valid), .log_word(log_word), .log_write(log_write));

// >>> rt_extended_option_register_test.sv
`timescale 1ns/1ps
`include "rtopt_defs.vh"
module rt_extended_option_register_test;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, msg_done = 0;
  reg mg = 0, mb = 0, busy = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, r;
  reg [12:0] low = 13'h0;
  reg [8:0] ev = 9'h0, en = 9'h0;
  wire [31:0] prdata;
  wire pready, pslverr, mv, lw, irq, pp;
  reg hb;
  reg [8:0] hev, hen;
  wire [15:0] mw, lword;
  integer seed = 32'h847d, mismatches = 0, compares = 0, i;
  reg e, o3, o2;
  always #20 pclk = ~pclk;
  rtopt_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .msg_done(msg_done), .msg_info_low(low), .msg_gap_error(mg),
    .msg_broadcast(mb), .event_raw(ev), .event_enable(en), .terminal_busy(busy),
    .msg_info_word(mw), .msg_info_valid(mv), .log_word(lword), .log_write(lw),
    .ping_pong_toggle_off(pp), .irq(irq));
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // word index to byte address
  task apb(input w, input [7:0] idx, input [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 2'b00, idx, 2'b00, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `RTOPT_IDX_OPTIONS, 0); chk(r, 32'h0);
    apb(1, `RTOPT_IDX_OPTIONS, 32'hFFFF_FFE2); apb(0, `RTOPT_IDX_OPTIONS, 0);
    chk(r, 32'h2);
    chk(pp, 1);
    apb(0, 8'h4C, 0); chk({r[30:0], e}, 32'h1);
    $display("registers done");
    for (i = 0; i < 24; i = i + 1) begin
      o3 = $random(seed);
      apb(1, `RTOPT_IDX_OPTIONS, {o3, 3'h0});
      @(posedge pclk) {msg_done, mg, mb, low} <= {1'b1, 2'($random(seed)), 13'($random(seed))};
      @(posedge pclk) msg_done <= 0;
      @(posedge pclk) chk({mv, mw}, {3'b100, o3 ? mb : mg, low});
    end
    $display("message words done");
    apb(1, `RTOPT_IDX_IRQ_MASK, 0);
    for (i = 0; i < 40; i = i + 1) begin
      o2 = $random(seed);
      apb(1, `RTOPT_IDX_OPTIONS, {o2, 2'h0});
      @(posedge pclk) {hb, hev, hen} = {1'($random(seed)), 9'($random(seed)), 9'($random(seed))};
      if (i % 4 == 0) hev = 9'h0;
      {busy, ev, en} <= {hb, hev, hen};
      @(posedge pclk) ev <= 0;
      @(posedge pclk) chk({lw, lw ? lword : 16'h0}, {|(hev & hen), 6'h0, |(hev & hen) & o2 & hb, hev & hen});
      apb(0, `RTOPT_IDX_PENDING, 0); chk(r[31:9], 0);
    end
    en <= 9'h1FF;
    ev <= 9'h001;
    @(posedge pclk) ev <= 0;
    repeat (3) @(posedge pclk); chk(irq, 0);
    apb(1, `RTOPT_IDX_IRQ_MASK, 3); repeat (2) @(posedge pclk); chk(irq, 1);
    apb(1, `RTOPT_IDX_IRQ_STATUS, 3); repeat (2) @(posedge pclk); chk(irq, 0);
    $display("interrupts done");
    summarize;
  end
  initial begin
    #400000;
    mismatches = mismatches + 1;
    summarize;
  end
endmodule // rt_extended_option_register_test
